// [rtl/tcu_top.sv]
// Timer compare unit top: registers, four compare channels, pin routing
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
module tcu_top
  import tcu_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [TCU_AW-1:0]  addr,
  input  wire logic [TCU_DW-1:0]  wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [TCU_DW-1:0]  rdata_q,
  input  wire logic               ext_clk_i,
  input  wire logic               adc_en,
  output logic      [TCU_NCH-1:0] pin_o_q,
  output logic      [TCU_NCH-1:0] pin_oe_q,
  output logic      [TCU_NCH-1:0] alt_o_q,
  output logic      [TCU_NCH-1:0] alt_oe_q,
  output logic                    conv_start_q
);

  //==========================================================================
  // Address decode helper
  function automatic logic ch_hit(
    input logic [TCU_AW-1:0] a,
    input logic [1:0]        idx,
    input logic [1:0]        fld
  );
    ch_hit = (a[TCU_AREA_BIT] == TCU_CH_AREA) &&
             (a[TCU_IDX_MSB:TCU_IDX_LSB] == idx) &&
             (a[1:0] == fld);
  endfunction

  //==========================================================================
  // State
  logic [TCU_DW-1:0]  ctl_q [TCU_NCH];
  logic [TCU_TW-1:0]  val_q [TCU_NCH];
  logic [1:0]         tctl_q;
  logic [TCU_NCH-1:0] flag_q;
  logic               ovf_q;
  logic [1:0]         rela_q;
  logic [1:0]         relb_q;
  logic [TCU_NCH-1:0] dir_q;
  logic [TCU_NCH-1:0] port_q;

  // Per-channel wires, overflow and read-mux wires
  logic [TCU_NCH-1:0] ctl_zero;
  logic [TCU_NCH-1:0] match_w;
  logic [TCU_NCH-1:0] latch_w;
  logic [TCU_NCH-1:0] sev_w;
  logic [TCU_NCH-1:0] sev_hold_w;
  logic [TCU_NCH-1:0] reloc;
  logic [TCU_NCH-1:0] flag_clr;
  logic               ovf_w;
  logic               ovf_clr;
  logic [TCU_DW-1:0]  rd_val;

  // Global register write strobes
  logic wr_tlo;
  logic wr_thi;
  logic wr_tctl;
  logic wr_flags;
  logic wr_rela;
  logic wr_relb;
  logic wr_dir;
  logic wr_port;

  assign wr_tlo   = wr && (addr == TCU_ADR_TLO);
  assign wr_thi   = wr && (addr == TCU_ADR_THI);
  assign wr_tctl  = wr && (addr == TCU_ADR_TCTL);
  assign wr_flags = wr && (addr == TCU_ADR_FLAGS);
  assign wr_rela  = wr && (addr == TCU_ADR_RELA);
  assign wr_relb  = wr && (addr == TCU_ADR_RELB);
  assign wr_dir   = wr && (addr == TCU_ADR_DIR);
  assign wr_port  = wr && (addr == TCU_ADR_PORT);

  // Write-one-to-clear of the flag register
  assign flag_clr = wr_flags ? wdata[TCU_NCH-1:0] : '0;
  assign ovf_clr  = wr_flags & wdata[TCU_FLG_OVF];

  // Relocation bits: register a for channels 0 and 1, b for 2 and 3
  assign reloc = {relb_q, rela_q};  // [RL10]

  //==========================================================================
  // Shared timer
  tcu_tmr_if tmr ();

  assign tmr.sev_hold = sev_hold_w;

  tcu_timer u_timer (
    .clk       (clk),
    .rst_n     (rst_n),
    .tmr       (tmr.timer),
    .run       (tctl_q[TCU_TC_RUN]),
    .ext_sel   (tctl_q[TCU_TC_EXT]),
    .ext_clk_i (ext_clk_i),
    .wr_lo     (wr_tlo),
    .wr_hi     (wr_thi),
    .wdata     (wdata),
    .ovf_o     (ovf_w)
  );

  //==========================================================================
  // Four compare channels with their own registers
  for (genvar i = 0; i < TCU_NCH; i++) begin : g_ch  // [RL2]
    logic wr_ctl;
    logic wr_vlo;
    logic wr_vhi;
    logic own_pin;
    logic pin_val;

    assign wr_ctl = wr && ch_hit(addr, 2'(i), TCU_OFS_CTL);
    assign wr_vlo = wr && ch_hit(addr, 2'(i), TCU_OFS_VLO);
    assign wr_vhi = wr && ch_hit(addr, 2'(i), TCU_OFS_VHI);

    // Whole control register written as zero
    assign ctl_zero[i] = wr_ctl && (wdata == TCU_CTL_RST);  // [RL7]

    // Control register; standard channels keep no upper bits
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl_q[i] <= TCU_CTL_RST;
      end else if (wr_ctl) begin
        if (i < TCU_NENH) begin
          ctl_q[i] <= wdata;
        end else begin
          ctl_q[i] <= wdata & TCU_STD_MASK;  // [RL11]
        end
      end
    end

    // Compare value register pair
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        val_q[i] <= TCU_VAL_RST;
      end else if (wr_vlo) begin
        val_q[i][7:0] <= wdata;
      end else if (wr_vhi) begin
        val_q[i][15:8] <= wdata;
      end
    end

    tcu_channel u_ch (
      .clk        (clk),
      .rst_n      (rst_n),
      .mode       (ctl_q[i][TCU_MODE_MSB:TCU_MODE_LSB]),  // [RL4]
      .value      (val_q[i]),
      .ctl_zero   (ctl_zero[i]),
      .tmr        (tmr.chan),
      .match_o    (match_w[i]),
      .latch_o    (latch_w[i]),
      .sev_o      (sev_w[i]),
      .sev_hold_o (sev_hold_w[i])
    );

    // Match flag: a match in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flag_q[i] <= 1'b0;
      end else if (match_w[i]) begin
        flag_q[i] <= 1'b1;  // [RL5]
      end else if (flag_clr[i]) begin
        flag_q[i] <= 1'b0;
      end
    end

    // Pin value: compare latch only in pin-driving modes
    assign own_pin = tcu_drives_pin(ctl_q[i][TCU_MODE_MSB:TCU_MODE_LSB]);  // [RL12] [RL13]
    assign pin_val = own_pin ? latch_w[i] : port_q[i];

    // Pin outputs, routed to the primary or alternative location
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_o_q[i]  <= 1'b0;
        pin_oe_q[i] <= 1'b0;
        alt_o_q[i]  <= 1'b0;
        alt_oe_q[i] <= 1'b0;
      end else begin
        pin_o_q[i]  <= ~reloc[i] & pin_val;  // [RL10]
        pin_oe_q[i] <= ~reloc[i] & ~dir_q[i];  // [RL6]
        alt_o_q[i]  <= reloc[i] & pin_val;
        alt_oe_q[i] <= reloc[i] & ~dir_q[i];
      end
    end
  end

  //==========================================================================
  // Timer control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tctl_q <= '0;
    end else if (wr_tctl) begin
      tctl_q <= wdata[1:0];  // [RL8] [RL9]
    end
  end

  // Timer overflow flag: overflow wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else if (ovf_w) begin
      ovf_q <= 1'b1;
    end else if (ovf_clr) begin
      ovf_q <= 1'b0;
    end
  end

  // Pin relocation registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rela_q <= '0;
      relb_q <= '0;
    end else begin
      if (wr_rela) begin
        rela_q <= wdata[1:0];
      end
      if (wr_relb) begin
        relb_q <= wdata[1:0];
      end
    end
  end

  // Pin direction and port data latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q  <= TCU_DIR_RST;
      port_q <= '0;
    end else begin
      if (wr_dir) begin
        dir_q <= wdata[TCU_NCH-1:0];
      end
      if (wr_port) begin
        port_q <= wdata[TCU_NCH-1:0];
      end
    end
  end

  //==========================================================================
  // Conversion start on any trigger while the converter is enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= adc_en & (|sev_w);  // [RL13]
    end
  end

  //==========================================================================
  // Read mux; unmapped addresses and bits read zero
  always_comb begin
    rd_val = '0;
    if (addr[TCU_AREA_BIT] == TCU_CH_AREA) begin
      case (addr[1:0])
        TCU_OFS_CTL: rd_val = ctl_q[addr[TCU_IDX_MSB:TCU_IDX_LSB]];
        TCU_OFS_VLO: rd_val = val_q[addr[TCU_IDX_MSB:TCU_IDX_LSB]][7:0];
        TCU_OFS_VHI: rd_val = val_q[addr[TCU_IDX_MSB:TCU_IDX_LSB]][15:8];
        default:     rd_val = '0;  // [RL11]
      endcase
    end else begin
      case (addr)
        TCU_ADR_TLO:   rd_val = tmr.count[7:0];
        TCU_ADR_THI:   rd_val = tmr.count[15:8];
        TCU_ADR_TCTL:  rd_val = {6'h00, tctl_q};
        TCU_ADR_FLAGS: rd_val = {3'h0, ovf_q, flag_q};
        TCU_ADR_RELA:  rd_val = {6'h00, rela_q};
        TCU_ADR_RELB:  rd_val = {6'h00, relb_q};
        TCU_ADR_DIR:   rd_val = {4'h0, dir_q};
        TCU_ADR_PORT:  rd_val = {4'h0, port_q};
        default:       rd_val = '0;  // [RL11]
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (rd) begin
      rdata_q <= rd_val;
    end else begin
      rdata_q <= '0;
    end
  end

endmodule

// [include/tcu_pkg.sv]
// Constants, types and helpers shared by the timer compare unit
//==========================================================================
// Behaviour
// RL1: Compare each 16-bit compare value with the 16-bit timer count continuously.
// RL2: Four identical compare instances, two enhanced, each with own registers.
// RL3: A match toggles, sets or clears the pin, triggers, or interrupts only.
// RL4: The low four control bits choose the action taken on the pin.
// RL5: Every compare mode sets the match flag together with the action.
// RL6: Software clears the pin direction bit before relying on pin actions.
// RL7: Writing zero to a control register clears the compare latch only.
// RL8: Software keeps the timer synchronous while compare is in use.
// RL9: Software clocks the timer from clock/4 or external, never system clock.
// RL10: Each module pin can be routed to an alternative pin location.
// RL11: Unimplemented bits, upper standard control bits included, read zero.
// RL12: Code 1010 raises only the flag and leaves the pin alone.
// RL13: Code 1011 issues a trigger: timer reset, conversion start; pin free.
// RL14: Trigger resets the timer at the next timer tick, without overflow flag.
// RL15: No timer reset if the match no longer holds at that tick.
// RL16: Codes 0010 toggle, 1000 set, 1001 clear; unlisted codes stay inactive.
package tcu_pkg;

  //==========================================================================
  // Sizes
  localparam int unsigned TCU_NCH  = 4;
  localparam int unsigned TCU_NENH = 2;
  localparam int unsigned TCU_AW   = 5;
  localparam int unsigned TCU_DW   = 8;
  localparam int unsigned TCU_TW   = 16;

  //==========================================================================
  // Register map: addr[4] clear selects a channel window, addr[3:2] its index
  localparam int unsigned     TCU_AREA_BIT  = 4;
  localparam logic            TCU_CH_AREA   = 1'b0;
  localparam int unsigned     TCU_IDX_MSB   = 3;
  localparam int unsigned     TCU_IDX_LSB   = 2;
  localparam logic [1:0]      TCU_OFS_CTL   = 2'h0;
  localparam logic [1:0]      TCU_OFS_VLO   = 2'h1;
  localparam logic [1:0]      TCU_OFS_VHI   = 2'h2;
  localparam logic [4:0]      TCU_ADR_TLO   = 5'h10;
  localparam logic [4:0]      TCU_ADR_THI   = 5'h11;
  localparam logic [4:0]      TCU_ADR_TCTL  = 5'h12;
  localparam logic [4:0]      TCU_ADR_FLAGS = 5'h13;
  localparam logic [4:0]      TCU_ADR_RELA  = 5'h14;
  localparam logic [4:0]      TCU_ADR_RELB  = 5'h15;
  localparam logic [4:0]      TCU_ADR_DIR   = 5'h16;
  localparam logic [4:0]      TCU_ADR_PORT  = 5'h17;

  //==========================================================================
  // Fields and reset values
  localparam int unsigned     TCU_MODE_LSB  = 0;
  localparam int unsigned     TCU_MODE_MSB  = 3;
  localparam logic [7:0]      TCU_STD_MASK  = 8'h3f;
  localparam int unsigned     TCU_TC_RUN    = 0;
  localparam int unsigned     TCU_TC_EXT    = 1;
  localparam int unsigned     TCU_FLG_OVF   = 4;
  localparam logic [7:0]      TCU_CTL_RST   = 8'h00;
  localparam logic [15:0]     TCU_VAL_RST   = 16'h0000;
  localparam logic [3:0]      TCU_DIR_RST   = 4'hf;
  localparam logic [15:0]     TCU_CNT_MAX   = 16'hffff;
  localparam int unsigned     TCU_DIV       = 4;
  localparam logic [1:0]      TCU_DIV_LAST  = 2'(TCU_DIV - 1);

  //==========================================================================
  // Compare mode codes
  typedef enum logic [3:0] {
    TCU_M_OFF    = 4'h0,
    TCU_M_TOGGLE = 4'h2,
    TCU_M_SET    = 4'h8,
    TCU_M_CLEAR  = 4'h9,
    TCU_M_SWI    = 4'ha,
    TCU_M_SEV    = 4'hb
  } tcu_mode_t;

  // Any code that makes matches count
  function automatic logic tcu_is_compare(input logic [3:0] m);
    case (m)
      TCU_M_TOGGLE, TCU_M_SET, TCU_M_CLEAR, TCU_M_SWI, TCU_M_SEV: tcu_is_compare = 1'b1;
      default: tcu_is_compare = 1'b0;
    endcase
  endfunction

  // Codes that take control of the module output pin
  function automatic logic tcu_drives_pin(input logic [3:0] m);
    case (m)
      TCU_M_TOGGLE, TCU_M_SET, TCU_M_CLEAR: tcu_drives_pin = 1'b1;
      default: tcu_drives_pin = 1'b0;
    endcase
  endfunction

endpackage

// [include/tcu_tmr_if.sv]
// Shared timer count and tick between the timer and compare channels
`timescale 1ns/1ns
interface tcu_tmr_if;
  import tcu_pkg::*;
  logic [TCU_TW-1:0]  count;
  logic               tick;
  logic [TCU_NCH-1:0] sev_hold;

  modport timer (output count, output tick, input sev_hold);
  modport chan  (input count, input tick);
endinterface

// [rtl/tcu_timer.sv]
// Shared 16-bit timer with clock/4 or external tick and trigger reset
`timescale 1ns/1ns
module tcu_timer
  import tcu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  tcu_tmr_if.timer               tmr,
  input  wire logic              run,
  input  wire logic              ext_sel,
  input  wire logic              ext_clk_i,
  input  wire logic              wr_lo,
  input  wire logic              wr_hi,
  input  wire logic [TCU_DW-1:0] wdata,
  output logic                   ovf_o
);
  logic [1:0]        div_q;
  logic              ext_s1_q;
  logic              ext_s2_q;
  logic              ext_s3_q;
  logic [TCU_TW-1:0] cnt_q;
  logic              sev_rst;

  //==========================================================================
  // Instruction clock divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // External clock synchroniser and edge stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign tmr.tick = run & (ext_sel ? (ext_s2_q & ~ext_s3_q) : (div_q == TCU_DIV_LAST));

  // Pending trigger whose match still holds
  assign sev_rst = |tmr.sev_hold;  // [RL15]

  //==========================================================================
  // Count: software write, then trigger reset, then increment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (wr_lo) begin
      cnt_q[7:0] <= wdata;
    end else if (wr_hi) begin
      cnt_q[15:8] <= wdata;
    end else if (tmr.tick) begin
      cnt_q <= sev_rst ? '0 : cnt_q + 16'h0001;  // [RL14]
    end
  end

  assign tmr.count = cnt_q;
  // Overflow only on a real wrap, never on trigger reset
  assign ovf_o = tmr.tick & ~sev_rst & ~wr_lo & ~wr_hi & (cnt_q == TCU_CNT_MAX);  // [RL14]
endmodule

// [rtl/tcu_channel.sv]
// One compare instance: match detect, output latch and trigger
`timescale 1ns/1ns
module tcu_channel
  import tcu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        mode,
  input  wire logic [TCU_TW-1:0] value,
  input  wire logic              ctl_zero,
  tcu_tmr_if.chan                tmr,
  output logic                   match_o,
  output logic                   latch_o,
  output logic                   sev_o,
  output logic                   sev_hold_o
);
  logic eq;
  logic eq_q;
  logic pend_q;
  logic latch_q;

  // Equality and its first cycle
  assign eq      = (tmr.count == value);  // [RL1]
  assign match_o = eq & ~eq_q & tcu_is_compare(mode);  // [RL16]
  assign sev_o   = match_o & (mode == TCU_M_SEV);  // [RL13]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eq_q <= 1'b0;
    end else begin
      eq_q <= eq;
    end
  end

  //==========================================================================
  // Compare output latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
    end else if (ctl_zero) begin
      latch_q <= 1'b0;  // [RL7]
    end else if (match_o) begin
      case (tcu_mode_t'(mode))  // [RL3] [RL4]
        TCU_M_TOGGLE: latch_q <= ~latch_q;
        TCU_M_SET:    latch_q <= 1'b1;
        TCU_M_CLEAR:  latch_q <= 1'b0;
        default:      latch_q <= latch_q;  // [RL12]
      endcase
    end
  end

  assign latch_o = latch_q;

  // Trigger pending until next timer tick; a new trigger wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (sev_o) begin
      pend_q <= 1'b1;  // [RL14]
    end else if (tmr.tick) begin
      pend_q <= 1'b0;
    end
  end

  assign sev_hold_o = pend_q & eq & (mode == TCU_M_SEV);  // [RL15]
endmodule

// [dv/tcu_pin_load.sv]
// Load model of the circuitry that hangs on both pin locations
`timescale 1ns/1ns
module tcu_pin_load
  import tcu_pkg::*;
(
  input  wire logic [TCU_NCH-1:0] pin_o_q,
  input  wire logic [TCU_NCH-1:0] pin_oe_q,
  input  wire logic [TCU_NCH-1:0] alt_o_q,
  input  wire logic [TCU_NCH-1:0] alt_oe_q,
  output logic      [TCU_NCH-1:0] lvl,
  output logic      [TCU_NCH-1:0] alt_lvl
);
  // ====================
  // Levels seen on the board
  // Undriven pins fall to the pull-down level
  assign lvl     = pin_o_q & pin_oe_q;
  assign alt_lvl = alt_o_q & alt_oe_q;
endmodule

// [dv/tcu_checker.sv]
// Port-level assertions for the timer compare unit
`timescale 1ns/1ns
module tcu_checker
  import tcu_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [TCU_AW-1:0]  addr,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [TCU_DW-1:0]  rdata_q,
  input wire logic               adc_en,
  input wire logic [TCU_NCH-1:0] pin_o_q,
  input wire logic [TCU_NCH-1:0] pin_oe_q,
  input wire logic [TCU_NCH-1:0] alt_o_q,
  input wire logic [TCU_NCH-1:0] alt_oe_q,
  input wire logic               conv_start_q
);
  // ====================
  // Clocking
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ====================
  // Register reads
  property p_idle_rd; !$past(rd) |-> rdata_q == 8'h00; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside read slot");
  property p_gap_rd; rd && !addr[4] && addr[1:0] == 2'h3 |=> rdata_q == 8'h00; endproperty
  a_gap_rd: assert property (p_gap_rd) else $error("window gap not zero");
  property p_std_top; rd && addr[4:3] == 2'b01 && addr[1:0] == 2'h0 |=> rdata_q[7:6] == 2'b00;
  endproperty
  a_std_top: assert property (p_std_top) else $error("standard control top bits set");
  property p_flag_top; rd && addr == TCU_ADR_FLAGS |=> rdata_q[7:5] == 3'h0; endproperty
  a_flag_top: assert property (p_flag_top) else $error("flag top bits set");
  property p_rel_top; rd && (addr == TCU_ADR_RELA || addr == TCU_ADR_RELB) |=> rdata_q[7:2] == 6'h00;
  endproperty
  a_rel_top: assert property (p_rel_top) else $error("relocation top bits set");
  property p_hi_area; rd && addr > 5'h17 |=> rdata_q == 8'h00; endproperty
  a_hi_area: assert property (p_hi_area) else $error("unmapped read not zero");

  // ====================
  // Pin locations
  property p_one_loc; (pin_oe_q & alt_oe_q) == 4'h0; endproperty
  a_one_loc: assert property (p_one_loc) else $error("both pin locations driven");
  property p_alt_idle; (alt_o_q & pin_o_q) == 4'h0; endproperty
  a_alt_idle: assert property (p_alt_idle) else $error("pin value on both locations");
  property p_oe_cause; $changed(pin_oe_q) |-> $past(wr) || $past(wr, 2) || $past(wr, 3); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive enable moved unasked");

  // ====================
  // Conversion trigger
  property p_conv_one; conv_start_q |=> !conv_start_q; endproperty
  a_conv_one: assert property (p_conv_one) else $error("conversion start too long");
  property p_conv_adc; conv_start_q |-> $past(adc_en); endproperty
  a_conv_adc: assert property (p_conv_adc) else $error("conversion start while disabled");
endmodule

bind tcu_top tcu_checker u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .adc_en(adc_en), .pin_o_q(pin_o_q), .pin_oe_q(pin_oe_q), .alt_o_q(alt_o_q),
  .alt_oe_q(alt_oe_q), .conv_start_q(conv_start_q));

// [dv/tcu_top_tb_top.sv]
// Self-checking testbench of the timer compare unit
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tcu_top_tb_top;
  import tcu_pkg::*;
  // ====================
  // Stimulus and observation
  localparam logic [3:0] MSEQ [10] = '{4'h8, 4'h9, 4'h8, 4'h0, 4'h2, 4'h2, 4'ha, 4'hb, 4'h5, 4'hf};
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic               ext_clk_i = 1'b0;
  logic               adc_en = 1'b0;
  logic [TCU_AW-1:0]  addr = 5'h00;
  logic [TCU_DW-1:0]  wdata = 8'h00;
  logic [TCU_DW-1:0]  rdata_q;
  logic [TCU_NCH-1:0] pin_o_q, pin_oe_q, alt_o_q, alt_oe_q, lvl, alt_lvl, lat;
  logic               conv_start_q;
  logic [31:0]        seed = 32'h0001738b;
  int                 err_total = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  int                 conv_cnt = 0;

  tcu_top u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .ext_clk_i(ext_clk_i), .adc_en(adc_en), .pin_o_q(pin_o_q),
    .pin_oe_q(pin_oe_q), .alt_o_q(alt_o_q), .alt_oe_q(alt_oe_q), .conv_start_q(conv_start_q));
  tcu_pin_load u_load (.pin_o_q(pin_o_q), .pin_oe_q(pin_oe_q), .alt_o_q(alt_o_q),
    .alt_oe_q(alt_oe_q), .lvl(lvl), .alt_lvl(alt_lvl));

  // Clock
  always #5 clk = ~clk;
  // Cycle count, trigger count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conv_start_q === 1'b1) conv_cnt <= conv_cnt + 1;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end

  // ====================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic drv(input logic [3:0] m);
    return m inside {4'h2, 4'h8, 4'h9};
  endfunction
  function automatic logic act(input logic [3:0] m);
    return drv(m) || m inside {4'ha, 4'hb};
  endfunction
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic w2(input logic [4:0] a1, input logic [7:0] d1, input logic [4:0] a2,
                    input logic [7:0] d2);
    wr_reg(a1, d1);
    wr_reg(a2, d2);
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK("register", e, d)
  endtask
  task automatic pulse_ext();
    ext_clk_i <= 1'b1;
    repeat (5) @(posedge clk);
    ext_clk_i <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic close_out();
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ====================
  // Main sequence
  initial begin
    logic [7:0] d, f;
    logic [15:0] v;
    logic [3:0] m, p, r;
    int k;
    lat = 4'h0;
    k = 0;
    p = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("oe reset", 4'h0, pin_oe_q)
    // Register file per channel
    for (int i = 0; i < 4; i++) begin
      rd_chk(5'(4 * i), 8'h00);
      d = 8'(xs());
      wr_reg(5'(4 * i), d);
      rd_chk(5'(4 * i), i > 1 ? d & 8'h3f : d);
      wr_reg(5'(4 * i + 2), d ^ 8'h5a);
      rd_chk(5'(4 * i + 2), d ^ 8'h5a);
      rd_chk(5'(4 * i + 3), 8'h00);
      wr_reg(5'(4 * i), 8'h00);
    end
    rd_chk(5'h1f, 8'h00);
    wr_reg(5'h16, 8'h00);
    repeat (3) @(posedge clk);
    `CHK("oe out", 4'hf, pin_oe_q)
    // Every mode on every channel, timer on the divided clock
    for (int i = 0; i < 4; i++) foreach (MSEQ[j]) begin
      m = MSEQ[j];
      k++;
      d = 8'(xs());
      v = {(k % 2 == 1) ? 8'h02 : 8'h01, d | 8'h10};
      p = 4'(xs());
      wr_reg(5'h12, 8'h00);
      w2(5'h11, v[15:8], 5'h10, v[7:0] - 8'h06);
      w2(5'(4 * i + 1), v[7:0], 5'(4 * i + 2), v[15:8]);
      w2(5'h17, {4'h0, p}, 5'h13, 8'h1f);
      wr_reg(5'(4 * i), {4'h0, m});
      if (m == 4'h0) lat[i] = 1'b0;
      repeat (3) @(posedge clk);
      `CHK("pin before", drv(m) ? lat[i] : p[i], lvl[i])
      wr_reg(5'h12, 8'h01);
      f = 8'h00;
      for (int n = 0; n < 40 && !f[i]; n++) rd_reg(5'h13, f);
      `CHK("flags", act(m) ? 8'(1 << i) : 8'h00, f)
      if (m == 4'h2) lat[i] = ~lat[i];
      else if (m == 4'h8) lat[i] = 1'b1;
      else if (m == 4'h9) lat[i] = 1'b0;
      repeat (3) @(posedge clk);
      `CHK("pin after", drv(m) ? lat[i] : p[i], lvl[i])
    end
    // Trigger on a standard channel, external timer clock
    wr_reg(5'h12, 8'h02);
    w2(5'h11, 8'h02, 5'h10, 8'hff);
    w2(5'h0d, 8'h00, 5'h0e, 8'h03);
    w2(5'h13, 8'h1f, 5'h0c, 8'h0b);
    adc_en <= 1'b1;
    wr_reg(5'h12, 8'h03);
    pulse_ext();
    rd_chk(5'h10, 8'h00);
    rd_chk(5'h11, 8'h03);
    rd_chk(5'h13, 8'h08);
    `CHK("conv", 1, conv_cnt)
    pulse_ext();
    rd_chk(5'h10, 8'h00);
    rd_chk(5'h11, 8'h00);
    rd_chk(5'h13, 8'h08);
    // Match withdrawn before the timer tick
    adc_en <= 1'b0;
    w2(5'h11, 8'h02, 5'h10, 8'hff);
    pulse_ext();
    wr_reg(5'h0d, 8'h05);
    pulse_ext();
    rd_chk(5'h10, 8'h01);
    rd_chk(5'h11, 8'h03);
    `CHK("conv", 1, conv_cnt)
    // Relocation and direction
    wr_reg(5'h12, 8'h00);
    r = 4'(xs());
    w2(5'h14, {6'h00, r[1:0]}, 5'h15, {6'h00, r[3:2]});
    rd_chk(5'h15, {6'h00, r[3:2]});
    repeat (2) @(posedge clk);
    `CHK("alt oe", r, alt_oe_q)
    `CHK("pin oe", ~r, pin_oe_q)
    `CHK("alt level", p & r, alt_lvl)
    wr_reg(5'h16, 8'h0f);
    repeat (3) @(posedge clk);
    `CHK("oe input", 4'h0, pin_oe_q | alt_oe_q)
    close_out();
  end
endmodule
